// *** rtl/eosr_defines.vh ***
/*
 * Constants for the event and operation status register block:
 * bit positions, masks, reset values, query selects and error numbers.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef EOSR_DEFINES_VH
`define EOSR_DEFINES_VH

// Event status bit positions
`define EOSR_EV_OPC        0
`define EOSR_EV_QUERY_ERR  2
`define EOSR_EV_DEV_ERR    3
`define EOSR_EV_EXEC_ERR   4
`define EOSR_EV_CMD_ERR    5
`define EOSR_EV_USER_REQ   6
`define EOSR_EV_POWER_ON   7

// Operation status bit positions
`define EOSR_OP_CAL        0
`define EOSR_OP_HARDCOPY   8
`define EOSR_OP_SCAN_AVAIL 9
`define EOSR_OP_SCAN_BREAK 10
`define EOSR_OP_THRESHOLD  12

// Implemented-bit masks; other bits of the event status and operation event registers read zero
`define EOSR_EV_MASK       8'hFD
`define EOSR_OP_MASK       16'h1701

// Reset values
`define EOSR_EV_RESET      8'h80
`define EOSR_ESE_RESET     8'h00
`define EOSR_OPEN_RESET    16'h0000

// Query selects
`define EOSR_Q_EVENT       3'h0
`define EOSR_Q_ESE         3'h1
`define EOSR_Q_OP_EVENT    3'h2
`define EOSR_Q_OP_COND     3'h3
`define EOSR_Q_OP_ENABLE   3'h4

// Error numbers, two's complement 16 bit
`define EOSR_ERR_CMD       16'hFF9C
`define EOSR_ERR_EXEC      16'hFF38
`define EOSR_ERR_DEV       16'hFED4
`define EOSR_ERR_DEV_LOW   16'hFE71

// Synchroniser depth for pin inputs
`define EOSR_SYNC_STAGES   3

`endif

// *** rtl/eosr_pin_sync.v ***
/*
 * Three-stage pin synchroniser with rising-edge pulse.
 * Assumes an asynchronous level input and the block clock sys_clk.
 */
`timescale 1ns/10ps
`include "eosr_defines.vh"

module eosr_pin_sync (
   // Clock and reset
   input  wire sys_clk,
   input  wire rst_n,
   // Pin side
   input  wire pin_in,
   // Synchronised side
   output reg  level,
   output reg  rise
);

   reg  [`EOSR_SYNC_STAGES-1:0] stage;

   ////////////////////////////////////////////////////////////////////////
   // Shift chain; first stage only feeds the second
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         stage <= 3'h0;
      end else begin
         stage <= {stage[1:0], pin_in};
      end
   end

   // Level changes once stages two and three agree
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         level <= 1'b0;
         rise  <= 1'b0;
      end else begin
         rise <= 1'b0;
         if (stage[1] == stage[2] && stage[2] != level) begin
            level <= stage[2];
            rise  <= stage[2];
         end
      end
   end

endmodule

// *** rtl/eosr_status_regs.v ***
/*
 * Event status register with enable mask, operation status register
 * with condition, event and enable parts, summary bits for the status
 * byte, error queue push port and scan-break pause control.
 * Assumes a command parser on sys_clk that issues one-cycle strobes,
 * and asynchronous operator pins for local key and threshold.
 */
`timescale 1ns/10ps
`include "eosr_defines.vh"

// Contract
// - Operation complete set after prior commands finish
// - Query protocol violation sets event bit 2
// - Device error sets bit 3, enqueues code unless a command or execution error comes in the same cycle
// - Execution error sets bit 4, enqueues code unless a command error comes in the same cycle
// - Command error sets bit 5, enqueues code
// - Local key press sets event bit 6
// - Power-up sets event bit 7
// - Enable mask written by enable-set command
// - Event query returns event status contents
// - Operation bit 0 follows calibration run
// - Operation bit 8 while hardcopy prints
// - Operation bit 9 on scan results ready
// - Operation bit 10 at range end, pause
// - Operation bit 15 always reads zero
// - Condition part live, event part latched
// - Event summary from masked event bits
// - Operation summary from masked event bits
module eosr_status_regs (
   // Clock and reset
   input  wire        sys_clk,
   input  wire        rst_n,
   // Command strobes from the parser
   input  wire        opc_cmd,
   input  wire        cmds_idle,
   input  wire        qry_strobe,
   input  wire [2:0]  qry_sel,
   input  wire        ese_write,
   input  wire        op_enable_write,
   input  wire [15:0] wr_data,
   input  wire        result_feed_always_cmd,
   input  wire        result_feed_off_cmd,
   input  wire        continue_measurement_cmd,
   // Error reports from the parser and executor
   input  wire        query_error,
   input  wire        dev_error,
   input  wire [15:0] dev_error_code,
   input  wire        exec_error,
   input  wire        cmd_error,
   // Instrument activity
   input  wire        calibration_running,
   input  wire        hardcopy_busy,
   input  wire        scan_block_ready,
   input  wire        scan_range_end,
   // Operator pins
   input  wire        local_key_pin,
   input  wire        threshold_pin,
   // Query answer
   output reg         resp_valid,
   output reg  [15:0] resp_data,
   // Error queue push
   output reg         err_push,
   output reg  [15:0] err_code,
   // Summaries and control
   output reg         event_summary,
   output reg         oper_summary,
   output reg         scan_paused,
   output reg         result_feed_on
);

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   reg  [7:0]  event_status;
   reg  [7:0]  event_enable;
   reg  [15:0] op_event;
   reg  [15:0] op_enable;
   reg  [15:0] op_cond_q;
   reg         opc_pending;
   reg         scan_avail;
   reg  [7:0]  next_event_status;
   reg  [15:0] next_op_event;
   reg  [15:0] op_cond;
   wire        local_level;
   wire        local_rise;
   wire        thresh_level;
   wire        thresh_rise;
   wire        read_event;
   wire        read_op_event;

   ////////////////////////////////////////////////////////////////////////
   // Functions

   // Keeps a device error number inside its legal span
   function [15:0] dev_code_fix;
      input [15:0] code;
      begin
         if (!code[15] && code != 16'h0000) begin
            dev_code_fix = code;
         end else if ($signed(code) <= $signed(`EOSR_ERR_DEV) &&
                      $signed(code) >= $signed(`EOSR_ERR_DEV_LOW)) begin
            dev_code_fix = code;
         end else begin
            dev_code_fix = `EOSR_ERR_DEV;
         end
      end
   endfunction

   // Sets one bit of an 8-bit vector when a condition holds
   function [7:0] set_bit8;
      input [7:0] vec;
      input integer pos;
      input       cond;
      begin
         set_bit8 = vec;
         if (cond) begin
            set_bit8[pos] = 1'b1;
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Operator pin synchronisers
   eosr_pin_sync u_local_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (local_key_pin),
      .level   (local_level),
      .rise    (local_rise)
   );

   eosr_pin_sync u_thresh_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pin_in  (threshold_pin),
      .level   (thresh_level),
      .rise    (thresh_rise)
   );

   // Destructive reads of the event parts
   assign read_event    = qry_strobe && (qry_sel == `EOSR_Q_EVENT);
   assign read_op_event = qry_strobe && (qry_sel == `EOSR_Q_OP_EVENT);

   ////////////////////////////////////////////////////////////////////////
   // Operation-complete wait for prior commands
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         opc_pending <= 1'b0;
      end else if (opc_cmd && !cmds_idle) begin
         opc_pending <= 1'b1;
      end else if (cmds_idle) begin
         opc_pending <= 1'b0;
      end
   end

   // Event status next value; new events win over the read clear
   always @* begin
      next_event_status = read_event ? 8'h00 : event_status;
      next_event_status = set_bit8(next_event_status, `EOSR_EV_OPC,
                                   cmds_idle && (opc_pending || opc_cmd));
      next_event_status = set_bit8(next_event_status, `EOSR_EV_QUERY_ERR,
                                   query_error);
      next_event_status = set_bit8(next_event_status, `EOSR_EV_DEV_ERR,
                                   dev_error);
      next_event_status = set_bit8(next_event_status, `EOSR_EV_EXEC_ERR,
                                   exec_error);
      next_event_status = set_bit8(next_event_status, `EOSR_EV_CMD_ERR,
                                   cmd_error);
      next_event_status = set_bit8(next_event_status, `EOSR_EV_USER_REQ,
                                   local_rise);
      next_event_status = next_event_status & `EOSR_EV_MASK;
   end

   // Event status and enable registers
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         event_status <= `EOSR_EV_RESET;
         event_enable <= `EOSR_ESE_RESET;
      end else begin
         event_status <= next_event_status;
         if (ese_write) begin
            event_enable <= wr_data[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Error queue push, command error first
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         err_push <= 1'b0;
         err_code <= 16'h0000;
      end else begin
         err_push <= cmd_error || exec_error || dev_error;
         if (cmd_error) begin
            err_code <= `EOSR_ERR_CMD;
         end else if (exec_error) begin
            err_code <= `EOSR_ERR_EXEC;
         end else if (dev_error) begin
            err_code <= dev_code_fix(dev_error_code);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result feed mode and scan-break pause
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         result_feed_on <= 1'b0;
         scan_paused    <= 1'b0;
         scan_avail     <= 1'b0;
      end else begin
         if (result_feed_always_cmd) begin
            result_feed_on <= 1'b1;
         end else if (result_feed_off_cmd) begin
            result_feed_on <= 1'b0;
         end
         if (scan_range_end) begin
            scan_paused <= 1'b1;
         end else if (continue_measurement_cmd) begin
            scan_paused <= 1'b0;
         end
         scan_avail <= scan_block_ready && result_feed_on;
      end
   end

   // Live condition part of the operation register
   always @* begin
      op_cond                      = 16'h0000;
      op_cond[`EOSR_OP_CAL]        = calibration_running;
      op_cond[`EOSR_OP_HARDCOPY]   = hardcopy_busy;
      op_cond[`EOSR_OP_SCAN_AVAIL] = scan_avail;
      op_cond[`EOSR_OP_SCAN_BREAK] = scan_paused;
      op_cond[`EOSR_OP_THRESHOLD]  = thresh_level;
   end

   // Event part latches rising conditions; set wins over read clear
   always @* begin
      next_op_event = read_op_event ? 16'h0000 : op_event;
      next_op_event = next_op_event | (op_cond & ~op_cond_q);
      if (thresh_rise) begin
         next_op_event[`EOSR_OP_THRESHOLD] = 1'b1;
      end
      next_op_event = next_op_event & `EOSR_OP_MASK;
   end

   // Operation event, enable and condition history
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         op_event  <= 16'h0000;
         op_enable <= `EOSR_OPEN_RESET;
         op_cond_q <= 16'h0000;
      end else begin
         op_event  <= next_op_event;
         op_cond_q <= op_cond;
         if (op_enable_write) begin
            op_enable <= wr_data & 16'h7FFF;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Summary bits toward the status byte
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         event_summary <= 1'b0;
         oper_summary  <= 1'b0;
      end else begin
         event_summary <= |(event_status & event_enable);
         oper_summary  <= |(op_event & op_enable);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Query answers, one cycle after the strobe
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         resp_valid <= 1'b0;
         resp_data  <= 16'h0000;
      end else begin
         resp_valid <= qry_strobe;
         if (qry_strobe) begin
            case (qry_sel)
               `EOSR_Q_EVENT: begin
                  resp_data <= {8'h00, event_status};
               end
               `EOSR_Q_ESE: begin
                  resp_data <= {8'h00, event_enable};
               end
               `EOSR_Q_OP_EVENT: begin
                  resp_data <= op_event;
               end
               `EOSR_Q_OP_COND: begin
                  resp_data <= op_cond;
               end
               `EOSR_Q_OP_ENABLE: begin
                  resp_data <= op_enable;
               end
               default: begin
                  resp_data <= 16'h0000;
               end
            endcase
         end
      end
   end

endmodule

// *** test/eosr_sr_asserts.sv ***
/* Port checker for the event and operation status block.
   Assumes a bind onto eosr_status_regs, single clock sys_clk. */
`timescale 1ns/10ps
module eosr_sr_asserts (
   // Clock and reset
   input logic        sys_clk,
   input logic        rst_n,
   // Commands
   input logic        qry_strobe,
   input logic [2:0]  qry_sel,
   input logic        ese_write,
   input logic [15:0] wr_data,
   input logic        result_feed_always_cmd,
   input logic        result_feed_off_cmd,
   input logic        continue_measurement_cmd,
   input logic        scan_range_end,
   // Errors
   input logic        cmd_error,
   input logic        exec_error,
   input logic        dev_error,
   // Outputs watched
   input logic        resp_valid,
   input logic [15:0] resp_data,
   input logic        err_push,
   input logic [15:0] err_code,
   input logic        scan_paused,
   input logic        result_feed_on
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Mask write, one idle cycle, then read-back
   sequence s_ese_wr;
      ese_write ##1 !ese_write;
   endsequence
   sequence s_ese_rd;
      s_ese_wr ##1 (qry_strobe && qry_sel == 3'h1 && !ese_write);
   endsequence
   property p_ese;
      s_ese_rd |=> resp_data == {8'h00, $past(wr_data[7:0], 3)};
   endproperty
   property p_resp;
      qry_strobe |=> resp_valid;
   endproperty
   property p_cmd;
      cmd_error |=> err_push && err_code == 16'hFF9C;
   endproperty
   property p_exec;
      exec_error && !cmd_error |=> err_push && err_code == 16'hFF38;
   endproperty
   property p_dev;
      dev_error && !cmd_error && !exec_error |=> err_push &&
         ($signed(err_code) > 0 || ($signed(err_code) >= -399 && $signed(err_code) <= -300));
   endproperty
   property p_brk;
      scan_range_end |=> scan_paused;
   endproperty
   property p_hold;
      scan_paused && !continue_measurement_cmd |=> scan_paused;
   endproperty
   property p_cont;
      continue_measurement_cmd && !scan_range_end |=> !scan_paused;
   endproperty
   property p_feed;
      result_feed_always_cmd && !result_feed_off_cmd |=> result_feed_on;
   endproperty
   property p_feed_off;
      result_feed_off_cmd && !result_feed_always_cmd |=> !result_feed_on;
   endproperty
   property p_quiet;
      !cmd_error && !exec_error && !dev_error |=> !err_push;
   endproperty
   a_ese: assert property (p_ese) else $error("enable read-back wrong");
   a_resp: assert property (p_resp) else $error("no query answer");
   a_cmd: assert property (p_cmd) else $error("command error push wrong");
   a_exec: assert property (p_exec) else $error("execution error push wrong");
   a_dev: assert property (p_dev) else $error("device error push wrong");
   a_brk: assert property (p_brk) else $error("no pause at range end");
   a_hold: assert property (p_hold) else $error("pause lost");
   a_cont: assert property (p_cont) else $error("pause not left");
   a_feed: assert property (p_feed) else $error("feed not enabled");
   a_feed_off: assert property (p_feed_off) else $error("feed not disabled");
   a_quiet: assert property (p_quiet) else $error("push without error");
endmodule
bind eosr_status_regs eosr_sr_asserts chk (
   .sys_clk                  (sys_clk),
   .rst_n                    (rst_n),
   .qry_strobe               (qry_strobe),
   .qry_sel                  (qry_sel),
   .ese_write                (ese_write),
   .wr_data                  (wr_data),
   .result_feed_always_cmd   (result_feed_always_cmd),
   .result_feed_off_cmd      (result_feed_off_cmd),
   .continue_measurement_cmd (continue_measurement_cmd),
   .scan_range_end           (scan_range_end),
   .cmd_error                (cmd_error),
   .exec_error               (exec_error),
   .dev_error                (dev_error),
   .resp_valid               (resp_valid),
   .resp_data                (resp_data),
   .err_push                 (err_push),
   .err_code                 (err_code),
   .scan_paused              (scan_paused),
   .result_feed_on           (result_feed_on)
);

// *** test/eosr_ctrl_model.sv ***
/* Remote controller model: command pulses, mask writes, queries.
   Assumes drive on the falling edge of sys_clk. */
`timescale 1ns/10ps
module eosr_ctrl_model (
   // Clock and answer
   input  logic        sys_clk,
   input  logic [15:0] resp_data,
   // Commands
   output logic        opc_cmd,
   output logic        qry_strobe,
   output logic [2:0]  qry_sel,
   output logic        ese_write,
   output logic        op_enable_write,
   output logic [15:0] wr_data,
   output logic        result_feed_always_cmd,
   output logic        result_feed_off_cmd,
   output logic        continue_measurement_cmd
);
   logic [3:0] cv;
   assign {continue_measurement_cmd, result_feed_off_cmd, result_feed_always_cmd, opc_cmd} = cv;
   // Idle values
   initial begin
      cv = 4'h0;
      {qry_strobe, ese_write, op_enable_write} = 3'h0;
      qry_sel = 3'h7;
      wr_data = 16'h5A5A;
   end
   // Pulse: 0 done, 1 feed on, 2 feed off, 3 resume after break
   task cmd(input int b);
      @(negedge sys_clk) cv[b] = 1'b1;
      @(negedge sys_clk) cv = 4'h0;
   endtask
   // Write: 0 event mask, 1 operation mask; data inverted after
   task wr(input int op, input logic [15:0] dt);
      @(negedge sys_clk) wr_data = dt;
      if (op == 0) ese_write = 1'b1;
      else op_enable_write = 1'b1;
      @(negedge sys_clk) {ese_write, op_enable_write} = 2'b00;
      wr_data = ~dt;
   endtask
   // Query, answer taken one cycle after the strobe
   task query(input logic [2:0] s, output logic [15:0] dt);
      @(negedge sys_clk) qry_strobe = 1'b1;
      qry_sel = s;
      @(negedge sys_clk) qry_strobe = 1'b0;
      qry_sel = ~s;
      dt = resp_data;
   endtask
endmodule

// *** test/tb.sv ***
/* Self-checking bench for the status register block.
   Assumes the controller model and the bound checker. */
`timescale 1ns/10ps
module tb;
   logic sys_clk = 1'b0, rst_n = 1'b0, cmds_idle = 1'b1;
   logic calibration_running = 1'b0, hardcopy_busy = 1'b0;
   logic local_key_pin = 1'b0, threshold_pin = 1'b0;
   logic [15:0] dev_error_code = 16'h0000, d, exp;
   logic signed [15:0] dc;
   logic [5:0] pv = 6'h00;
   int fail_count = 0, tests_run = 0, seed = 32'h2435, cyc = 0, ev, i, k;
   wire cmd_error, exec_error, dev_error, query_error, scan_block_ready, scan_range_end;
   wire opc_cmd, qry_strobe, ese_write, op_enable_write, result_feed_always_cmd;
   wire result_feed_off_cmd, continue_measurement_cmd, resp_valid, err_push;
   wire event_summary, oper_summary, scan_paused, result_feed_on;
   wire [2:0] qry_sel;
   wire [15:0] wr_data, resp_data, err_code;
   assign {cmd_error, exec_error, dev_error, query_error, scan_block_ready, scan_range_end} = pv;
   eosr_status_regs dut (
      .sys_clk                  (sys_clk),
      .rst_n                    (rst_n),
      .opc_cmd                  (opc_cmd),
      .cmds_idle                (cmds_idle),
      .qry_strobe               (qry_strobe),
      .qry_sel                  (qry_sel),
      .ese_write                (ese_write),
      .op_enable_write          (op_enable_write),
      .wr_data                  (wr_data),
      .result_feed_always_cmd   (result_feed_always_cmd),
      .result_feed_off_cmd      (result_feed_off_cmd),
      .continue_measurement_cmd (continue_measurement_cmd),
      .query_error              (query_error),
      .dev_error                (dev_error),
      .dev_error_code           (dev_error_code),
      .exec_error               (exec_error),
      .cmd_error                (cmd_error),
      .calibration_running      (calibration_running),
      .hardcopy_busy            (hardcopy_busy),
      .scan_block_ready         (scan_block_ready),
      .scan_range_end           (scan_range_end),
      .local_key_pin            (local_key_pin),
      .threshold_pin            (threshold_pin),
      .resp_valid               (resp_valid),
      .resp_data                (resp_data),
      .err_push                 (err_push),
      .err_code                 (err_code),
      .event_summary            (event_summary),
      .oper_summary             (oper_summary),
      .scan_paused              (scan_paused),
      .result_feed_on           (result_feed_on)
   );
   eosr_ctrl_model ctl (
      .sys_clk                  (sys_clk),
      .resp_data                (resp_data),
      .opc_cmd                  (opc_cmd),
      .qry_strobe               (qry_strobe),
      .qry_sel                  (qry_sel),
      .ese_write                (ese_write),
      .op_enable_write          (op_enable_write),
      .wr_data                  (wr_data),
      .result_feed_always_cmd   (result_feed_always_cmd),
      .result_feed_off_cmd      (result_feed_off_cmd),
      .continue_measurement_cmd (continue_measurement_cmd)
   );
   always #4 sys_clk = ~sys_clk;
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         results();
      end
   end
   task results();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] want);
      tests_run++;
      if (got !== want) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task pulse(input int b);
      @(negedge sys_clk) pv[b] = 1'b1;
      @(negedge sys_clk) pv = 6'h00;
   endtask
   // Event query against the model; the read clears it
   task qev();
      ctl.query(3'h0, d);
      chk({15'h0, resp_valid}, 16'h0001);
      chk(d, ev[15:0]);
      ev = 0;
   endtask
   initial begin
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      ev = 16'h0080;
      qev();
      qev();
      // Each error source; device codes inside and outside the span
      for (i = 0; i < 6; i++) begin
         k = (i > 3) ? 2 : i;
         dc = $random(seed) % 512;
         dev_error_code = dc;
         pulse(5 - k);
         exp = (k == 0) ? 16'hFF9C : (k == 1) ? 16'hFF38 :
               (dc > 0 || (dc >= -399 && dc <= -300)) ? dc : 16'hFED4;
         if (k != 3) begin
            chk({15'h0, err_push}, 16'h0001);
            chk(err_code, exp);
         end
         ev = 1 << (5 - k);
         qev();
      end
      // Completion waits for idle
      cmds_idle = 1'b0;
      ctl.cmd(0);
      repeat (3) @(negedge sys_clk);
      qev();
      cmds_idle = 1'b1;
      repeat (2) @(negedge sys_clk);
      ev = 1;
      qev();
      // Random masks against each error event
      for (i = 0; i < 4; i++) begin
         k = $random(seed);
         ctl.wr(0, k[15:0]);
         ctl.query(3'h1, d);
         chk(d, {8'h00, k[7:0]});
         pulse(5 - i);
         ev = 1 << (5 - i);
         repeat (2) @(negedge sys_clk);
         chk({15'h0, event_summary}, {15'h0, |(ev[7:0] & k[7:0])});
         qev();
      end
      local_key_pin = 1'b1;
      repeat (6) @(negedge sys_clk);
      ev = 16'h0040;
      qev();
      // Operation condition and event parts
      k = $random(seed);
      {calibration_running, hardcopy_busy, threshold_pin} = k[2:0];
      repeat (6) @(negedge sys_clk);
      exp = {3'h0, k[0], 3'h0, k[1], 7'h00, k[2]};
      ctl.query(3'h3, d);
      chk(d, exp);
      ctl.query(3'h2, d);
      chk(d, exp);
      ctl.query(3'h2, d);
      chk(d, 16'h0000);
      pulse(1);
      ctl.query(3'h2, d);
      chk(d, 16'h0000);
      ctl.cmd(1);
      chk({15'h0, result_feed_on}, 16'h0001);
      pulse(1);
      ctl.query(3'h2, d);
      chk(d, 16'h0200);
      pulse(0);
      chk({15'h0, scan_paused}, 16'h0001);
      ctl.query(3'h3, d);
      chk(d & 16'h0400, 16'h0400);
      ctl.cmd(3);
      chk({15'h0, scan_paused}, 16'h0000);
      ctl.wr(1, 16'hFFFF);
      ctl.query(3'h4, d);
      chk(d, 16'h7FFF);
      chk({15'h0, oper_summary}, 16'h0001);
      ctl.query(3'h2, d);
      chk(d, 16'h0400);
      repeat (2) @(negedge sys_clk);
      chk({15'h0, oper_summary}, 16'h0000);
      // Unknown select answers zero; feed off blocks scan results
      ctl.query(3'h6, d);
      chk(d, 16'h0000);
      ctl.cmd(2);
      chk({15'h0, result_feed_on}, 16'h0000);
      pulse(1);
      ctl.query(3'h2, d);
      chk(d, 16'h0000);
      results();
   end
endmodule
